/* bench/mbdsc_fabric_model.sv */
`timescale 1ns/1ps
module mbdsc_fabric_model (
	// pattern select from the bench
	input  wire logic [7:0]                     tag_i,
	// fabric operands
	output logic      [mbdsc_pkg::STAGE_W-1:0]  opa_o,
	output logic      [mbdsc_pkg::STAGE_W-1:0]  opb_o,
	// coupled memory read paths
	output logic      [mbdsc_pkg::MEM_W-1:0]    bram_o,
	output logic      [mbdsc_pkg::MEM_W-1:0]    rf_o
);
	import mbdsc_pkg::*;

	// a and b differ in every byte so a swapped lane shows up
	assign opa_o  = {9{tag_i}};
	assign opb_o  = {9{~tag_i}};
	// halves differ too, so a swapped 72-bit half of the memory operand is seen
	assign bram_o = {{9{tag_i ^ 8'h5a}}, {9{tag_i ^ 8'h3c}}};
	assign rf_o   = {{9{tag_i ^ 8'hc3}}, {9{tag_i ^ 8'h96}}};
endmodule : mbdsc_fabric_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import mbdsc_pkg::*;
	logic                clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]          wb_adr_i, tag;
	logic [3:0]          wb_sel_i, rstn_bus_i, rn2;
	logic [31:0]         wb_dat_i, wb_dat_o, rd;
	logic [CE_W-1:0]     ce_bus_i, ce2;
	logic [STAGE_W-1:0]  opa, opb, exp_a;
	logic [MEM_W-1:0]    bram, rf, lower_ops_o, upper_ops_o;
	logic [MULTS-1:0]    active_mult_o;
	logic [5:0]          max_products_o;
	int                  n_errors = 0;
	int                  checked = 0;
	byte unsigned        cnt_tbl[4][15] = '{'{12, 8, 6, 5, 4, 2, 10, 8, 5, 4, 4, 2, 1, 1, 1},
		'{24, 16, 12, 10, 8, 4, 16, 12, 8, 8, 6, 4, 2, 2, 2},
		'{24, 16, 12, 10, 8, 4, 20, 16, 10, 9, 8, 4, 2, 2, 2},
		'{32, 32, 16, 16, 16, 4, 32, 32, 16, 16, 16, 4, 2, 2, 2}};
	logic [MULTS-1:0]    mask_tbl[4] = '{MASK_X1, MASK_X2, MASK_X2SPL, MASK_X4};

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	mbdsc_fabric_model feed_u (.tag_i(tag), .opa_o(opa), .opb_o(opb), .bram_o(bram), .rf_o(rf));

	mbdsc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ce_bus_i(ce_bus_i), .rstn_bus_i(rstn_bus_i),
		.operand_a_i(opa), .operand_b_i(opb), .bram_dout_i(bram), .rf_dout_i(rf),
		.lower_ops_o(lower_ops_o), .upper_ops_o(upper_ops_o), .active_mult_o(active_mult_o),
		.max_products_o(max_products_o));

	task automatic chk(input string nm, input logic [143:0] exp, input logic [143:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// request held until ack is sampled high; only the watchdog ends a hang
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= wd;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		chk("ack_wait", 144'd2, 144'(n));
	endtask : wb

	task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		chk(nm, exp, rd);
	endtask : rd_chk

	// drive one edge of stage inputs, look after the capturing edge
	task automatic step(input logic [7:0] t, input logic [11:0] ce, input logic [3:0] rn);
		@(posedge clk_i);
		tag        <= t;
		ce_bus_i   <= ce;
		rstn_bus_i <= rn;
		@(posedge clk_i);
		#1;
	endtask : step

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		tally_and_finish();
	end

	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		tag = 8'h00;
		ce_bus_i = 12'h000;
		rstn_bus_i = 4'hf;
		exp_a = '0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk("mode", ADR_MODE, 32'h10);
		rd_chk("stage0", ADR_STAGE0, 32'h0);
		rd_chk("status", ADR_STATUS, 32'h0004000f);
		step(8'h11, 12'hfff, 4'h0);
		chk("lower", {{9{~8'h11}}, {9{8'h11}}}, lower_ops_o);
		chk("upper", {{9{~8'h11}}, {9{8'h11}}}, upper_ops_o);
		for (int m = 0; m < 4; m++)
			for (int f = 0; f < 15; f++)
				for (int e = 0; e < 2; e++) begin
					wb(1'b1, ADR_MODE, {24'h0, e[0], e[0], f[3:0], m[1:0]});
					repeat (2) @(posedge clk_i);
					#1;
					chk("mask", mask_tbl[m], active_mult_o);
					chk("count", cnt_tbl[m == 0 ? 0 : m == 3 ? 3 : 1 + e][f], max_products_o);
					chk("upper", m == 3 ? (e ? rf : bram) : {opb, opa}, upper_ops_o);
				end
		rd_chk("status", ADR_STATUS, 32'h0002ffff);
		rd_chk("mode", ADR_MODE, 32'hfb);
		wb(1'b1, ADR_STAGE0 + 8'h0c, 32'h1c);
		rd_chk("sel_err", ADR_STATUS, 32'h0042ffff);
		wb(1'b1, ADR_STATUS, 32'h0);
		rd_chk("status_ro", ADR_STATUS, 32'h0042ffff);
		wb(1'b1, 8'h44, 32'hffffffff);
		rd_chk("unmapped", 8'h40, 32'h0);
		wb(1'b1, ADR_STAGE0 + 8'h0c, 32'h0);
		wb(1'b1, ADR_MODE, 32'h10);
		$display("test modes done");
		// reset code 0 holds stage 0 clear before the enable sweep
		wb(1'b1, ADR_STAGE0, 32'h1b);
		step(8'h22, 12'h000, 4'hf);
		chk("clear", exp_a, lower_ops_o[71:0]);
		for (int c = 0; c < 14; c++) begin
			ce2 = (c == 0 || c == 13) ? 12'h000 : 12'h001 << (c - 1);
			wb(1'b1, ADR_STAGE0, 32'ha1 | (32'(c) << 1));
			step(8'h20 + 8'(c), ~ce2, 4'hf);
			if (c == 13)
				exp_a = {9{8'h20 + 8'(c)}};
			chk("ce_off", exp_a, lower_ops_o[71:0]);
			step(8'h40 + 8'(c), ce2, 4'hf);
			if (c != 0)
				exp_a = {9{8'h40 + 8'(c)}};
			chk("ce_on", exp_a, lower_ops_o[71:0]);
		end
		for (int r = 0; r < 6; r++) begin
			rn2 = r == 0 ? 4'hf : r == 5 ? 4'h0 : 4'h1 << (r - 1);
			wb(1'b1, ADR_STAGE0 + 8'h04, 32'h1b | (32'(r) << 5));
			step(8'h50 + 8'(r), 12'h000, ~rn2);
			chk("rst_on", r == 5 ? {9{~(8'h50 + 8'(r))}} : 72'h0, lower_ops_o[143:72]);
			step(8'h60 + 8'(r), 12'h000, rn2);
			chk("rst_off", r == 0 ? 72'h0 : {9{~(8'h60 + 8'(r))}}, lower_ops_o[143:72]);
		end
		// stage 1 has a fixed style, so its style bit must change nothing
		wb(1'b1, ADR_STAGE0, 32'h13b);
		wb(1'b1, ADR_STAGE0 + 8'h04, 32'h13b);
		step(8'h77, 12'h000, 4'hf);
		@(posedge clk_i);
		rstn_bus_i <= 4'he;
		#1;
		chk("async", 72'h0, lower_ops_o[71:0]);
		chk("sync_hold", {9{~8'h77}}, lower_ops_o[143:72]);
		chk("bypass_upper", {opb, opa}, upper_ops_o);
		@(posedge clk_i);
		#1;
		chk("sync_clr", 144'h0, lower_ops_o);
		$display("test stages done");
		tally_and_finish();
	end
endmodule : tb_top

/* rtl/mbdsc_cfg_if.sv */
`timescale 1ns/1ps
interface mbdsc_cfg_if;
	logic       del;
	logic [3:0] cesel;
	logic [2:0] rstsel;
	logic       rst_mode;

	modport ctrl  (output del, output cesel, output rstsel, output rst_mode);
	modport stage (input del, input cesel, input rstsel, input rst_mode);
endinterface : mbdsc_cfg_if

/* rtl/mbdsc_pkg.sv */
package mbdsc_pkg;

	// stage geometry
	localparam int unsigned STAGE_W  = 72;
	localparam int unsigned MEM_W    = 144;
	localparam int unsigned STAGES   = 4;
	localparam int unsigned CE_W     = 12;
	localparam int unsigned RSTN_W   = 4;
	localparam int unsigned MULTS    = 16;

	// stage index: lower half then upper half
	localparam int unsigned STG_LO_A = 0;
	localparam int unsigned STG_LO_B = 1;
	localparam int unsigned STG_HI_A = 2;
	localparam int unsigned STG_HI_B = 3;

	// register byte offsets
	localparam logic [7:0] ADR_STAGE0 = 8'h00;
	localparam logic [7:0] ADR_MODE   = 8'h10;
	localparam logic [7:0] ADR_STATUS = 8'h14;

	// stage config fields
	localparam int unsigned CFG_W        = 9;
	localparam int unsigned CFG_DEL      = 0;
	localparam int unsigned CFG_CESEL_LO = 1;
	localparam int unsigned CFG_RSEL_LO  = 5;
	localparam int unsigned CFG_RMODE    = 8;
	localparam logic [CFG_W-1:0] CFG_RST = 9'h000;

	// mode register fields
	localparam int unsigned MODE_W      = 8;
	localparam int unsigned MD_MULT_LO  = 0;
	localparam int unsigned MD_FMT_LO   = 2;
	localparam int unsigned MD_TWO_EXP  = 6;
	localparam int unsigned MD_MEM_SRC  = 7;
	localparam logic [MODE_W-1:0] MODE_RST = 8'h10;

	// status fields
	localparam int unsigned ST_CNT_LO = 16;
	localparam int unsigned ST_ERR    = 22;

	// selector codes
	localparam logic [3:0] CESEL_ZERO = 4'h0;
	localparam logic [3:0] CESEL_ONE  = 4'hd;
	localparam logic [2:0] RSEL_ZERO  = 3'h0;
	localparam logic [2:0] RSEL_ONE   = 3'h5;

	// multiplier count modes
	localparam logic [1:0] MULT_X1    = 2'h0;
	localparam logic [1:0] MULT_X2    = 2'h1;
	localparam logic [1:0] MULT_X2SPL = 2'h2;
	localparam logic [1:0] MULT_X4    = 2'h3;

	localparam logic [MULTS-1:0] MASK_X1    = 16'h000f;
	localparam logic [MULTS-1:0] MASK_X2    = 16'h00ff;
	localparam logic [MULTS-1:0] MASK_X2SPL = 16'h0f0f;
	localparam logic [MULTS-1:0] MASK_X4    = 16'hffff;

	typedef enum logic [3:0] {
		FMT_INT3 = 4'h0, FMT_INT4 = 4'h1, FMT_INT6 = 4'h2, FMT_INT7 = 4'h3,
		FMT_INT8 = 4'h4, FMT_INT16 = 4'h5,
		FMT_BFP3 = 4'h6, FMT_BFP4 = 4'h7, FMT_BFP6 = 4'h8, FMT_BFP7 = 4'h9,
		FMT_BFP8 = 4'ha, FMT_BFP16 = 4'hb,
		FMT_FP16 = 4'hc, FMT_HALF_FLOAT_WIDE_EXPONENT = 4'hd, FMT_FP24 = 4'he
	} mbdsc_fmt_type;

	function automatic logic mbdsc_ce_pick(input logic [3:0] code, input logic [CE_W-1:0] bus);
		if (code == CESEL_ZERO)
			return 1'b0;
		else if (code == CESEL_ONE)
			return 1'b1;
		else if (code > CESEL_ONE)
			return 1'b0;
		else
			return bus[code - 4'h1];
	endfunction : mbdsc_ce_pick

	function automatic logic mbdsc_rstn_pick(input logic [2:0] code, input logic [RSTN_W-1:0] bus);
		if (code == RSEL_ZERO)
			return 1'b0;
		else if (code == RSEL_ONE)
			return 1'b1;
		else if (code > RSEL_ONE)
			return 1'b0;
		else
			return bus[2'(code - 3'h1)];
	endfunction : mbdsc_rstn_pick

endpackage : mbdsc_pkg

/* rtl/mbdsc_stage.sv */
`timescale 1ns/1ps
module mbdsc_stage
	import mbdsc_pkg::*;
#(
	parameter bit ALLOW_ASYNC = 1'b0
) (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// configuration
	mbdsc_cfg_if.stage                 cfg,
	// shared enable and reset buses
	input  wire logic [CE_W-1:0]       ce_bus_i,
	input  wire logic [RSTN_W-1:0]     rstn_bus_i,
	// data
	input  wire logic [STAGE_W-1:0]    d_i,
	output logic      [STAGE_W-1:0]    q_o
);
	logic               ce_sel;
	logic               rstn_sel;
	logic               async_clr;
	logic [STAGE_W-1:0] q_r;
	logic [STAGE_W-1:0] q_nxt;

	assign ce_sel    = mbdsc_ce_pick(cfg.cesel, ce_bus_i);
	assign rstn_sel  = mbdsc_rstn_pick(cfg.rstsel, rstn_bus_i);
	// fixed-style stages ignore rst_mode entirely
	assign async_clr = ALLOW_ASYNC && cfg.rst_mode && cfg.del && !rstn_sel;

	always_comb begin
		q_nxt = q_r;
		if (cfg.del && !rstn_sel)
			q_nxt = '0;
		else if (cfg.del && ce_sel)
			q_nxt = d_i;
	end

	// async clear is glitch sensitive: selector changes while rstn is low clear the stage
	always_ff @(posedge clk_i or posedge async_clr) begin
		if (async_clr)
			q_r <= '0;
		else if (rst_i)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end

	assign q_o = cfg.del ? q_r : d_i;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_bypass_pass: assert property (!cfg.del |-> q_o == d_i)
		else $error("bypassed stage does not pass input");
	chk_ce_capture: assert property (cfg.del && rstn_sel && ce_sel |=> q_r == $past(d_i) || async_clr)
		else $error("enabled stage missed capture");
	chk_sync_clear: assert property (cfg.del && !rstn_sel |=> q_r == '0)
		else $error("stage not cleared by reset");
	chk_async_clear: assert property (async_clr |-> q_o == '0)
		else $error("async clear not immediate");
	chk_hold_idle: assert property (cfg.del && rstn_sel && !ce_sel && !async_clr ##1 !async_clr
		|-> q_r == $past(q_r))
		else $error("stage changed without enable");
	cov_async: cover property (async_clr);
	cov_capture: cover property (cfg.del && rstn_sel && ce_sel);
endmodule : mbdsc_stage

/* rtl/mbdsc_top.sv */
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module mbdsc_top (
	// clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           rst_i,
	// wishbone slave
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [7:0]                     wb_adr_i,
	input  wire logic [3:0]                     wb_sel_i,
	input  wire logic [31:0]                    wb_dat_i,
	output logic      [31:0]                    wb_dat_o,
	output logic                                wb_ack_o,
	// shared enable and reset buses
	input  wire logic [mbdsc_pkg::CE_W-1:0]     ce_bus_i,
	input  wire logic [mbdsc_pkg::RSTN_W-1:0]   rstn_bus_i,
	// fabric operands and coupled memory paths
	input  wire logic [mbdsc_pkg::STAGE_W-1:0]  operand_a_i,
	input  wire logic [mbdsc_pkg::STAGE_W-1:0]  operand_b_i,
	input  wire logic [mbdsc_pkg::MEM_W-1:0]    bram_dout_i,
	input  wire logic [mbdsc_pkg::MEM_W-1:0]    rf_dout_i,
	// staged operands per half
	output logic      [mbdsc_pkg::MEM_W-1:0]    lower_ops_o,
	output logic      [mbdsc_pkg::MEM_W-1:0]    upper_ops_o,
	// mode status
	output logic      [mbdsc_pkg::MULTS-1:0]    active_mult_o,
	output logic      [5:0]                     max_products_o
);
	import mbdsc_pkg::*;

	function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				res[i*8 +: 8] = wd[i*8 +: 8];
		end
		return res;
	endfunction : wb_merge

	// stage slots are word aligned below MODE; other offsets in that span read as zero
	function automatic logic is_stage_adr(input logic [7:0] adr);
		return adr < ADR_MODE && adr[1:0] == 2'h0;
	endfunction : is_stage_adr

	function automatic logic [MULTS-1:0] mult_mask(input logic [1:0] mode);
		case (mode)
			MULT_X1:    mult_mask = MASK_X1;
			MULT_X2:    mult_mask = MASK_X2;
			MULT_X2SPL: mult_mask = MASK_X2SPL;
			default:    mult_mask = MASK_X4;
		endcase
	endfunction : mult_mask

	// columns x1, x2, x4; bfp x2 column split by exponent count
	function automatic logic [5:0] max_products(input logic [3:0] fmt, input logic [1:0] mode,
		input logic two_exp);
		logic [5:0] c1;
		logic [5:0] c2;
		logic [5:0] c2b;
		logic [5:0] c4;
		c1 = 6'h00;
		c2 = 6'h00;
		c2b = 6'h00;
		c4 = 6'h00;
		case (fmt)
			FMT_INT3:  begin c1 = 6'd12; c2 = 6'd24; c2b = 6'd24; c4 = 6'd32; end
			FMT_INT4:  begin c1 = 6'd8;  c2 = 6'd16; c2b = 6'd16; c4 = 6'd32; end
			FMT_INT6:  begin c1 = 6'd6;  c2 = 6'd12; c2b = 6'd12; c4 = 6'd16; end
			FMT_INT7:  begin c1 = 6'd5;  c2 = 6'd10; c2b = 6'd10; c4 = 6'd16; end
			FMT_INT8:  begin c1 = 6'd4;  c2 = 6'd8;  c2b = 6'd8;  c4 = 6'd16; end
			FMT_INT16: begin c1 = 6'd2;  c2 = 6'd4;  c2b = 6'd4;  c4 = 6'd4;  end
			FMT_BFP3:  begin c1 = 6'd10; c2 = 6'd16; c2b = 6'd20; c4 = 6'd32; end
			FMT_BFP4:  begin c1 = 6'd8;  c2 = 6'd12; c2b = 6'd16; c4 = 6'd32; end
			FMT_BFP6:  begin c1 = 6'd5;  c2 = 6'd8;  c2b = 6'd10; c4 = 6'd16; end
			FMT_BFP7:  begin c1 = 6'd4;  c2 = 6'd8;  c2b = 6'd9;  c4 = 6'd16; end
			FMT_BFP8:  begin c1 = 6'd4;  c2 = 6'd6;  c2b = 6'd8;  c4 = 6'd16; end
			FMT_BFP16: begin c1 = 6'd2;  c2 = 6'd4;  c2b = 6'd4;  c4 = 6'd4;  end
			FMT_FP16, FMT_HALF_FLOAT_WIDE_EXPONENT, FMT_FP24: begin
				c1 = 6'd1;
				c2 = 6'd2;
				c2b = 6'd2;
				c4 = 6'd2;
			end
			default: c1 = 6'h00;
		endcase
		case (mode)
			MULT_X1: max_products = c1;
			MULT_X4: max_products = c4;
			default: max_products = two_exp ? c2b : c2;
		endcase
	endfunction : max_products

	logic [CFG_W-1:0]   stage_cfg_r   [STAGES];
	logic [CFG_W-1:0]   stage_cfg_nxt [STAGES];
	logic [MODE_W-1:0]  mode_r;
	logic [MODE_W-1:0]  mode_nxt;
	logic               ack_r;
	logic               ack_nxt;
	logic [31:0]        dat_r;
	logic [31:0]        dat_nxt;
	logic [MULTS-1:0]   active_r;
	logic [5:0]         count_r;
	logic [MULTS-1:0]   active_nxt;
	logic [5:0]         count_nxt;
	logic               cfg_err;
	logic               req;
	logic [MEM_W-1:0]   mem_sel;
	logic [STAGE_W-1:0] stage_d [STAGES];
	logic [STAGE_W-1:0] stage_q [STAGES];
	logic [31:0]        status_word;

	assign req = wb_cyc_i && wb_stb_i && !ack_r;

	// out-of-range selectors pick a constant zero; flagged for software
	always_comb begin
		cfg_err = 1'b0;
		for (int i = 0; i < STAGES; i++) begin
			if (stage_cfg_r[i][CFG_CESEL_LO +: 4] > CESEL_ONE ||
				stage_cfg_r[i][CFG_RSEL_LO +: 3] > RSEL_ONE)
				cfg_err = 1'b1;
		end
	end

	assign status_word = {9'h000, cfg_err, count_r, active_r};

	// mask and count lag MODE by one cycle so both outputs stay flop driven
	always_comb begin
		active_nxt = mult_mask(mode_r[MD_MULT_LO +: 2]);
		count_nxt  = max_products(mode_r[MD_FMT_LO +: 4], mode_r[MD_MULT_LO +: 2], mode_r[MD_TWO_EXP]);
	end

	always_comb begin
		stage_cfg_nxt = stage_cfg_r;
		mode_nxt = mode_r;
		ack_nxt = req;
		dat_nxt = 32'h0000_0000;
		if (req && wb_we_i) begin
			if (is_stage_adr(wb_adr_i))
				stage_cfg_nxt[wb_adr_i[3:2]] = CFG_W'(wb_merge(32'(stage_cfg_r[wb_adr_i[3:2]]),
					wb_dat_i, wb_sel_i));
			else if (wb_adr_i == ADR_MODE)
				mode_nxt = MODE_W'(wb_merge(32'(mode_r), wb_dat_i, wb_sel_i));
		end else if (req) begin
			if (is_stage_adr(wb_adr_i))
				dat_nxt = 32'(stage_cfg_r[wb_adr_i[3:2]]);
			else if (wb_adr_i == ADR_MODE)
				dat_nxt = 32'(mode_r);
			else if (wb_adr_i == ADR_STATUS)
				dat_nxt = status_word;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < STAGES; i++)
				stage_cfg_r[i] <= CFG_RST;
			mode_r   <= MODE_RST;
			ack_r    <= 1'b0;
			dat_r    <= 32'h0000_0000;
			active_r <= MASK_X1;
			count_r  <= 6'h00;
		end else begin
			stage_cfg_r <= stage_cfg_nxt;
			mode_r   <= mode_nxt;
			ack_r    <= ack_nxt;
			dat_r    <= dat_nxt;
			active_r <= active_nxt;
			count_r  <= count_nxt;
		end
	end

	assign wb_ack_o       = ack_r;
	assign wb_dat_o       = dat_r;
	assign active_mult_o  = active_r;
	assign max_products_o = count_r;

	// x4 takes the second operand pair from the coupled memory path
	assign mem_sel = mode_r[MD_MEM_SRC] ? rf_dout_i : bram_dout_i;
	assign stage_d[STG_LO_A] = operand_a_i;
	assign stage_d[STG_LO_B] = operand_b_i;
	assign stage_d[STG_HI_A] = (mode_r[MD_MULT_LO +: 2] == MULT_X4) ? mem_sel[STAGE_W-1:0] : operand_a_i;
	assign stage_d[STG_HI_B] = (mode_r[MD_MULT_LO +: 2] == MULT_X4) ? mem_sel[MEM_W-1:STAGE_W] : operand_b_i;

	// staged data is combinational when bypassed, so these are not flop outputs
	assign lower_ops_o = {stage_q[STG_LO_B], stage_q[STG_LO_A]};
	assign upper_ops_o = {stage_q[STG_HI_B], stage_q[STG_HI_A]};

	for (genvar g = 0; g < STAGES; g++) begin : g_stage
		mbdsc_cfg_if cfg_bus ();
		assign cfg_bus.del      = stage_cfg_r[g][CFG_DEL];
		assign cfg_bus.cesel    = stage_cfg_r[g][CFG_CESEL_LO +: 4];
		assign cfg_bus.rstsel   = stage_cfg_r[g][CFG_RSEL_LO +: 3];
		assign cfg_bus.rst_mode = stage_cfg_r[g][CFG_RMODE];
		mbdsc_stage #(
			.ALLOW_ASYNC ((g % 2) == 0)
		) u_stage (
			.clk_i      (clk_i),
			.rst_i      (rst_i),
			.cfg        (cfg_bus.stage),
			.ce_bus_i   (ce_bus_i),
			.rstn_bus_i (rstn_bus_i),
			.d_i        (stage_d[g]),
			.q_o        (stage_q[g])
		);
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_ack_single: assert property (ack_r |=> !ack_r)
		else $error("ack held more than one cycle");
	chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !ack_r |=> ack_r)
		else $error("request not acknowledged next cycle");
	chk_mask_x1: assert property (mode_r[1:0] == MULT_X1 |=> active_r == 16'h000f)
		else $error("x1 mask wrong");
	chk_mask_split: assert property (mode_r[1:0] == MULT_X2SPL |=> active_r == 16'h0f0f)
		else $error("x2 split mask wrong");
	chk_int8_x4: assert property (mode_r[5:0] == {FMT_INT8, MULT_X4} |=> count_r == 6'd16)
		else $error("int8 x4 count wrong");
	chk_bfp_two_exp: assert property (mode_r[6:0] == {1'b1, FMT_BFP3, MULT_X2} |=> count_r == 6'd20)
		else $error("bfp two exponent count wrong");
	chk_err_flag: assert property (stage_cfg_r[3][4:1] == 4'he |-> cfg_err)
		else $error("bad enable selector not flagged");

	// register bus side effects
	chk_dat_idle: assert property (!ack_r |-> dat_r == 32'h0000_0000)
		else $error("read data not zero outside ack");
	chk_mode_write: assert property (req && wb_we_i && wb_adr_i == ADR_MODE && wb_sel_i == 4'hf
		|=> mode_r == $past(wb_dat_i[MODE_W-1:0]))
		else $error("mode write not applied");
	chk_mode_read: assert property (req && !wb_we_i && wb_adr_i == ADR_MODE |=> dat_r == 32'($past(mode_r)))
		else $error("mode read data wrong");
	chk_stage_read: assert property (req && !wb_we_i && wb_adr_i == ADR_STAGE0
		|=> dat_r == 32'($past(stage_cfg_r[0])))
		else $error("stage read data wrong");
	chk_status_ro: assert property (req && wb_we_i && wb_adr_i == ADR_STATUS |=> mode_r == $past(mode_r))
		else $error("status write changed mode");
	chk_unmapped_rd: assert property (req && !wb_we_i && wb_adr_i > ADR_STATUS |=> dat_r == 32'h0000_0000)
		else $error("unmapped read not zero");

	// multiplier masks
	chk_mask_x2: assert property (mode_r[1:0] == MULT_X2 |=> active_r == 16'h00ff)
		else $error("x2 mask wrong");
	chk_mask_x4: assert property (mode_r[1:0] == MULT_X4 |=> active_r == 16'hffff)
		else $error("x4 mask wrong");

	// product counts: int, bfp and float corners for x2 and x4, int corners only for x1 and x2 split
	chk_int3_x1: assert property (mode_r[5:0] == {FMT_INT3, MULT_X1} |=> count_r == 6'd12)
		else $error("int3 x1 count wrong");
	chk_int4_x1: assert property (mode_r[5:0] == {FMT_INT4, MULT_X1} |=> count_r == 6'd8)
		else $error("int4 x1 count wrong");
	chk_int16_x2: assert property (mode_r[5:0] == {FMT_INT16, MULT_X2} |=> count_r == 6'd4)
		else $error("int16 x2 count wrong");
	chk_split_int8: assert property (mode_r[5:0] == {FMT_INT8, MULT_X2SPL} |=> count_r == 6'd8)
		else $error("x2 split count wrong");
	chk_bfp_four_exp: assert property (mode_r[6:0] == {1'b0, FMT_BFP3, MULT_X2} |=> count_r == 6'd16)
		else $error("bfp four exponent count wrong");
	chk_bfp7_two_exp: assert property (mode_r[6:0] == {1'b1, FMT_BFP7, MULT_X2} |=> count_r == 6'd9)
		else $error("bfp7 two exponent count wrong");
	chk_half_wide_x2: assert property (mode_r[5:0] == {FMT_HALF_FLOAT_WIDE_EXPONENT, MULT_X2} |=> count_r == 6'd2)
		else $error("wide exponent half float count wrong");
	chk_int6_x4: assert property (mode_r[5:0] == {FMT_INT6, MULT_X4} |=> count_r == 6'd16)
		else $error("int6 x4 count wrong");
	chk_bfp16_x4: assert property (mode_r[5:0] == {FMT_BFP16, MULT_X4} |=> count_r == 6'd4)
		else $error("bfp16 x4 count wrong");
	chk_fp24_x4: assert property (mode_r[5:0] == {FMT_FP24, MULT_X4} |=> count_r == 6'd2)
		else $error("fp24 x4 count wrong");

	// operand routing; outside x4 both halves see the fabric operands
	chk_mem_route: assert property (mode_r[1:0] == MULT_X4 |-> {stage_d[STG_HI_B], stage_d[STG_HI_A]} ==
		(mode_r[MD_MEM_SRC] ? rf_dout_i : bram_dout_i))
		else $error("x4 memory operand misrouted");
	chk_halves_match: assert property (mode_r[1:0] != MULT_X4 |->
		stage_d[STG_HI_A] == stage_d[STG_LO_A] && stage_d[STG_HI_B] == stage_d[STG_LO_B])
		else $error("halves fed differently outside x4");

	cov_x4: cover property (mode_r[1:0] == MULT_X4);
	cov_write: cover property (req && wb_we_i);
	cov_status: cover property (req && !wb_we_i && wb_adr_i == ADR_STATUS);
endmodule : mbdsc_top
